// ===== eeprom_ctl_pkg.sv
// Constants and types shared by the serial EEPROM command controller
package eeprom_ctl_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0]  CMD_OFS    = 8'h00;
	localparam logic [7:0]  DATA_OFS   = 8'h04;
	localparam logic [7:0]  HWCFG_OFS  = 8'h08;
	// Field positions
	localparam int          BUSY_BIT   = 31;
	localparam int          CMD_LSB    = 28;
	localparam int          OVF_BIT    = 18;
	localparam int          TMO_BIT    = 17;
	localparam int          LOADED_BIT = 16;
	localparam int          READY_BIT  = 0;
	// Reset values
	localparam logic        BUSY_RST   = 1'b1;
	localparam logic [2:0]  CMD_RST    = 3'h0;
	localparam logic [15:0] ADDR_RST   = 16'h0000;
	localparam logic [7:0]  BUF_RST    = 8'h00;
	// Command select encodings
	localparam logic [2:0]  CMD_READ   = 3'h0;
	localparam logic [2:0]  CMD_EW_OFF = 3'h1;
	localparam logic [2:0]  CMD_EW_ON  = 3'h2;
	localparam logic [2:0]  CMD_WRITE  = 3'h3;
	localparam logic [2:0]  CMD_WR_ALL = 3'h4;
	localparam logic [2:0]  CMD_ERASE  = 3'h5;
	localparam logic [2:0]  CMD_ER_ALL = 3'h6;
	localparam logic [2:0]  CMD_RELOAD = 3'h7;
	localparam logic [7:0]  SIGNATURE  = 8'ha5;
	// Timing
	localparam int          CLK_HZ      = 40_000_000;
	localparam int          CLK_NS      = 25;
	localparam int          TIMEOUT_MS  = 30;
	localparam int          TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int          LINK_QTR_NS = 1250;
	localparam int          QTR_CYC     = (LINK_QTR_NS + CLK_NS - 1) / CLK_NS;
	// Three-wire frame
	localparam int          TX_W        = 28;
	localparam logic [1:0]  OP_READ     = 2'b10;
	localparam logic [1:0]  OP_WRITE    = 2'b01;
	localparam logic [1:0]  OP_ERASE    = 2'b11;
	localparam logic [1:0]  OP_EXT      = 2'b00;
	localparam logic [1:0]  EXT_EW_ON   = 2'b11;
	localparam logic [1:0]  EXT_EW_OFF  = 2'b00;
	localparam logic [1:0]  EXT_WR_ALL  = 2'b01;
	localparam logic [1:0]  EXT_ER_ALL  = 2'b10;

	typedef enum logic [3:0] {
		st_idle, st_load, st_launch, st_bit, st_tw_end, st_wait_rdy,
		st_result, st_i2c_next, st_byte_end, st_istart, st_istop, st_done
	} fsm_type;

	typedef enum logic [2:0] {
		k_start, k_send, k_recv, k_stop, k_end
	} act_kind_type;

	typedef struct packed {
		act_kind_type kind;
		logic [7:0]   b;
	} act_type;

	typedef struct packed {
		fsm_type     state;
		logic        busy;
		logic [2:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  buf_byte;
		logic        tmo;
		logic        loaded;
		logic        ovf;
		logic        ready;
		logic [31:0] rdata;
		logic [7:0]  qcnt;
		logic        tick;
		logic [1:0]  phase;
		logic [5:0]  nbits;
		logic [5:0]  txlen;
		logic [5:0]  bidx;
		logic [TX_W-1:0] tx;
		logic [8:0]  rx;
		logic        cs;
		logic        sck;
		logic        sdo;
		logic        scl_out;
		logic        sda_out;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic [3:0]  step;
		logic        fail;
		logic        rd_op;
		logic        tw_wr;
		logic        loading;
		logic [15:0] xaddr;
		logic [7:0]  ld_cnt;
		logic [7:0]  cfg_data;
		logic        cfg_valid;
		logic [31:0] tcnt;
		logic [2:0]  s1;
		logic [2:0]  s2;
	} ctl_type;
endpackage

// ===== eeprom_ctl.sv
// Serial EEPROM command controller with three-wire and I2C master modes
//
// Contract
// - Read fetches target byte into byte buffer
// - Three-wire disable command blocks erase and write
// - Three-wire enable command allows erase and write
// - Write stores byte buffer at target location
// - Write-all stores byte buffer everywhere
// - Erase clears the targeted location
// - Erase-all clears the whole memory
// - Reload fails unless location zero holds signature
// - Reload drops ready until loading ends
// - Overrun flag bit 18 set past end
// - Overrun flag cleared by reload or reset
// - Timeout bit 17 on silent erase/write
// - I2C timeout on nack, stretch or unsupported
// - Timeout and loaded flags clear on one
// - Data input high means no timeout
// - Only erase/write kinds wait and time out in three-wire mode
// - Loaded flag bit 16 set on good load
// - Sixteen-bit target location, resets to zero
// - Busy written one starts command until done
`timescale 1ns/10ps
module eeprom_ctl #(
	parameter int          MW_ADDR_BITS   = 8,
	parameter logic [15:0] EE_LAST_ADDR   = 16'h00ff,
	parameter logic [6:0]  I2C_DEV_ADDR   = 7'h50,
	parameter int unsigned TIMEOUT_CYCLES = eeprom_ctl_pkg::TIMEOUT_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        i2c_mode,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             ee_cs,
	output logic             ee_sck,
	output logic             ee_sdo,
	input  wire logic        serial_data_in_pin,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	output logic             config_ready,
	output logic      [7:0]  cfg_data,
	output logic             cfg_valid
);
	import eeprom_ctl_pkg::*;

	ctl_type state_r;
	ctl_type state_nxt;

	////////////////////////////////////////////////////////////////////////
	// I2C byte sequence: random read or single byte write
	function automatic act_type i2c_act(input logic [3:0] step,
			input logic rd, input logic [15:0] a, input logic [7:0] d);
		act_type x;
		x.kind = k_end;
		x.b    = 8'hff;
		case (step)
			4'h0: x.kind = k_start;
			4'h1: begin
				x.kind = k_send;
				x.b    = {I2C_DEV_ADDR, 1'b0};
			end
			4'h2: begin
				x.kind = k_send;
				x.b    = a[15:8];
			end
			4'h3: begin
				x.kind = k_send;
				x.b    = a[7:0];
			end
			4'h4: begin
				x.kind = rd ? k_start : k_send;
				x.b    = d;
			end
			4'h5: begin
				x.kind = rd ? k_send : k_stop;
				x.b    = {I2C_DEV_ADDR, 1'b1};
			end
			4'h6: x.kind = rd ? k_recv : k_end;
			4'h7: x.kind = rd ? k_stop : k_end;
			default: x.kind = k_end;
		endcase
		return x;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [2:0]  op;
		logic [1:0]  opc;
		logic [15:0] fa;
		logic [7:0]  fd;
		logic [5:0]  tl;
		logic [5:0]  rl;
		logic [31:0] rv;
		logic        scl_s;
		logic        din;
		logic [7:0]  rbyte;
		logic        last;
		act_type     act;
		op        = state_r.loading ? CMD_READ : state_r.cmd;
		opc       = OP_EXT;
		fa        = state_r.xaddr;
		fd        = 8'h00;
		tl        = 6'(3 + MW_ADDR_BITS);
		rl        = 6'h00;
		rv        = 32'h0000_0000;
		scl_s     = state_r.s2[1];
		din       = i2c_mode ? state_r.s2[0] : state_r.s2[2];
		rbyte     = i2c_mode ? state_r.rx[8:1] : state_r.rx[7:0];
		last      = (state_r.bidx + 6'h01) == state_r.nbits;
		act       = i2c_act(state_r.step, state_r.rd_op, state_r.xaddr,
			state_r.buf_byte);
		state_nxt = state_r;

		state_nxt.s1        = {serial_data_in_pin, scl_in, sda_in};
		state_nxt.s2        = state_r.s1;
		state_nxt.rdata     = 32'h0000_0000;
		state_nxt.cfg_valid = 1'b0;
		state_nxt.tick      = 1'b0;
		if (state_r.qcnt == 8'(QTR_CYC - 1)) begin
			state_nxt.qcnt = 8'h00;
			state_nxt.tick = 1'b1;
		end else begin
			state_nxt.qcnt = state_r.qcnt + 8'h01;
		end

		// Three-wire instruction frame
		case (op)
			CMD_READ: begin
				opc = OP_READ;
				rl  = 6'h08;
			end
			CMD_EW_OFF: fa = 16'(EXT_EW_OFF) << (MW_ADDR_BITS - 2);
			CMD_EW_ON: fa = 16'(EXT_EW_ON) << (MW_ADDR_BITS - 2);
			CMD_WRITE: begin
				opc = OP_WRITE;
				fd  = state_r.buf_byte;
				tl  = 6'(11 + MW_ADDR_BITS);
			end
			CMD_WR_ALL: begin
				fa = 16'(EXT_WR_ALL) << (MW_ADDR_BITS - 2);
				fd = state_r.buf_byte;
				tl = 6'(11 + MW_ADDR_BITS);
			end
			CMD_ERASE: opc = OP_ERASE;
			CMD_ER_ALL: fa = 16'(EXT_ER_ALL) << (MW_ADDR_BITS - 2);
			default: opc = OP_EXT;
		endcase

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				CMD_OFS: begin
					if (reg_wdata[TMO_BIT])
						state_nxt.tmo = 1'b0;
					if (reg_wdata[LOADED_BIT])
						state_nxt.loaded = 1'b0;
					if (!state_r.busy) begin
						state_nxt.cmd  = reg_wdata[CMD_LSB+:3];
						state_nxt.addr = reg_wdata[15:0];
						state_nxt.busy = reg_wdata[BUSY_BIT];
					end
				end
				DATA_OFS: begin
					if (!state_r.busy)
						state_nxt.buf_byte = reg_wdata[7:0];
				end
				default: ;
			endcase
		end

		// Register reads, answered the next cycle
		if (reg_rd) begin
			case (reg_addr)
				CMD_OFS: begin
					rv[BUSY_BIT]     = state_r.busy;
					rv[CMD_LSB+:3]   = state_r.cmd;
					rv[OVF_BIT]      = state_r.ovf;
					rv[TMO_BIT]      = state_r.tmo;
					rv[LOADED_BIT]   = state_r.loaded;
					rv[15:0]         = state_r.addr;
				end
				DATA_OFS: rv[7:0] = state_r.buf_byte;
				HWCFG_OFS: rv[READY_BIT] = state_r.ready;
				default: rv = 32'h0000_0000;
			endcase
			state_nxt.rdata = rv;
		end

		// Clock stretch and response wait share one counter
		if (i2c_mode && state_r.phase == 2'h2 && !scl_s &&
				(state_r.state == st_bit || state_r.state == st_istart ||
				state_r.state == st_istop)) begin
			state_nxt.tcnt = state_r.tcnt + 32'h1;
			if (state_r.tcnt >= TIMEOUT_CYCLES - 1) begin
				state_nxt.tmo   = 1'b1;
				state_nxt.state = st_done;
			end
		end

		case (state_r.state)
			st_idle: begin
				if (state_r.busy) begin
					if (state_r.cmd == CMD_RELOAD) begin
						state_nxt.state = st_load;
					end else begin
						state_nxt.xaddr = state_r.addr;
						state_nxt.state = st_launch;
					end
				end
			end
			st_load: begin
				state_nxt.loading = 1'b1;
				state_nxt.busy    = 1'b1;
				state_nxt.ready   = 1'b0;
				state_nxt.loaded  = 1'b0;
				state_nxt.ovf     = 1'b0;
				state_nxt.xaddr   = 16'h0000;
				state_nxt.state   = st_launch;
			end
			st_launch: begin
				state_nxt.rd_op = (op == CMD_READ);
				state_nxt.tw_wr = (op == CMD_WRITE) || (op == CMD_WR_ALL) ||
					(op == CMD_ERASE) || (op == CMD_ER_ALL);
				state_nxt.fail  = 1'b0;
				state_nxt.tcnt  = 32'h0;
				state_nxt.phase = 2'h0;
				state_nxt.bidx  = 6'h00;
				state_nxt.step  = 4'h0;
				if (i2c_mode) begin
					if (op == CMD_READ || op == CMD_WRITE) begin
						state_nxt.state = st_i2c_next;
					end else begin
						state_nxt.tmo   = 1'b1;
						state_nxt.state = st_done;
					end
				end else begin
					state_nxt.tx    = {1'b1, opc, fa[MW_ADDR_BITS-1:0], fd,
						{(TX_W - 11 - MW_ADDR_BITS){1'b0}}};
					state_nxt.txlen = tl;
					state_nxt.nbits = tl + rl;
					state_nxt.cs    = 1'b1;
					state_nxt.state = st_bit;
				end
			end
			st_bit: begin
				if (state_r.tick) begin
					case (state_r.phase)
						2'h0: begin
							if (i2c_mode)
								state_nxt.sda_oe_n = state_r.tx[TX_W-1];
							else
								state_nxt.sdo = (state_r.bidx < state_r.txlen) &&
									state_r.tx[TX_W-1];
							state_nxt.phase = 2'h1;
						end
						2'h1: begin
							state_nxt.sck      = !i2c_mode;
							state_nxt.scl_oe_n = 1'b1;
							state_nxt.phase    = 2'h2;
						end
						2'h2: begin
							if (!i2c_mode || scl_s) begin
								state_nxt.rx    = {state_r.rx[7:0], din};
								state_nxt.tcnt  = 32'h0;
								state_nxt.phase = 2'h3;
							end
						end
						default: begin
							state_nxt.sck      = 1'b0;
							state_nxt.scl_oe_n = !i2c_mode;
							state_nxt.tx       = {state_r.tx[TX_W-2:0], 1'b0};
							state_nxt.bidx     = state_r.bidx + 6'h01;
							state_nxt.phase    = 2'h0;
							if (last) begin
								state_nxt.cs    = 1'b0;
								state_nxt.state = i2c_mode ? st_byte_end :
									st_tw_end;
							end
						end
					endcase
				end
			end
			st_tw_end: begin
				if (state_r.tick) begin
					if (state_r.tw_wr) begin
						state_nxt.cs    = 1'b1;
						state_nxt.tcnt  = 32'h0;
						state_nxt.state = st_wait_rdy;
					end else begin
						state_nxt.state = state_r.rd_op ? st_result : st_done;
					end
				end
			end
			st_wait_rdy: begin
				state_nxt.tcnt = state_r.tcnt + 32'h1;
				if (din) begin
					state_nxt.cs    = 1'b0;
					state_nxt.state = st_done;
				end else if (state_r.tcnt >= TIMEOUT_CYCLES - 1) begin
					state_nxt.tmo   = 1'b1;
					state_nxt.cs    = 1'b0;
					state_nxt.state = st_done;
				end
			end
			st_result: begin
				state_nxt.state = st_launch;
				if (!state_r.loading) begin
					state_nxt.buf_byte = rbyte;
					state_nxt.state    = st_done;
				end else if (state_r.xaddr == 16'h0000) begin
					if (rbyte != SIGNATURE)
						state_nxt.state = st_done;
				end else if (state_r.xaddr == 16'h0001) begin
					state_nxt.ld_cnt = rbyte;
					if (rbyte == 8'h00) begin
						state_nxt.loaded = 1'b1;
						state_nxt.state  = st_done;
					end
				end else begin
					state_nxt.cfg_data  = rbyte;
					state_nxt.cfg_valid = 1'b1;
					state_nxt.ld_cnt    = state_r.ld_cnt - 8'h01;
					if (state_r.ld_cnt == 8'h01) begin
						state_nxt.loaded = 1'b1;
						state_nxt.state  = st_done;
					end
				end
				if (state_nxt.state == st_launch) begin
					if (state_r.xaddr == EE_LAST_ADDR) begin
						state_nxt.ovf   = 1'b1;
						state_nxt.state = st_done;
					end else begin
						state_nxt.xaddr = state_r.xaddr + 16'h0001;
					end
				end
			end
			st_i2c_next: begin
				state_nxt.phase = 2'h0;
				state_nxt.bidx  = 6'h00;
				state_nxt.nbits = 6'h09;
				case (act.kind)
					k_start: state_nxt.state = st_istart;
					k_send: begin
						state_nxt.tx    = {act.b, 1'b1, {(TX_W - 9){1'b0}}};
						state_nxt.state = st_bit;
					end
					k_recv: begin
						state_nxt.tx    = {9'h1ff, {(TX_W - 9){1'b0}}};
						state_nxt.state = st_bit;
					end
					k_stop: state_nxt.state = st_istop;
					default: state_nxt.state = state_r.rd_op ? st_result :
						st_done;
				endcase
			end
			st_byte_end: begin
				if (act.kind == k_send && state_r.rx[0]) begin
					state_nxt.tmo   = 1'b1;
					state_nxt.fail  = 1'b1;
					state_nxt.state = st_istop;
				end else begin
					state_nxt.step  = state_r.step + 4'h1;
					state_nxt.state = st_i2c_next;
				end
			end
			st_istart, st_istop: begin
				if (state_r.tick) begin
					case (state_r.phase)
						2'h0: begin
							state_nxt.sda_oe_n = state_r.state == st_istart;
							state_nxt.phase    = 2'h1;
						end
						2'h1: begin
							state_nxt.scl_oe_n = 1'b1;
							state_nxt.phase    = 2'h2;
						end
						2'h2: begin
							if (scl_s) begin
								state_nxt.sda_oe_n = state_r.state == st_istop;
								state_nxt.tcnt     = 32'h0;
								state_nxt.phase    = 2'h3;
							end
						end
						default: begin
							state_nxt.scl_oe_n = state_r.state == st_istop;
							state_nxt.phase    = 2'h0;
							state_nxt.step     = state_r.step + 4'h1;
							state_nxt.state    = state_r.fail ? st_done :
								st_i2c_next;
						end
					endcase
				end
			end
			st_done: begin
				state_nxt.busy     = 1'b0;
				state_nxt.loading  = 1'b0;
				state_nxt.fail     = 1'b0;
				state_nxt.cs       = 1'b0;
				state_nxt.sck      = 1'b0;
				state_nxt.sdo      = 1'b0;
				state_nxt.scl_oe_n = 1'b1;
				state_nxt.sda_oe_n = 1'b1;
				if (state_r.loading)
					state_nxt.ready = 1'b1;
				state_nxt.state = st_idle;
			end
			default: state_nxt.state = st_idle;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r          <= '0;
			state_r.state    <= st_load;
			state_r.busy     <= BUSY_RST;
			state_r.cmd      <= CMD_RST;
			state_r.addr     <= ADDR_RST;
			state_r.buf_byte <= BUF_RST;
			state_r.scl_oe_n <= 1'b1;
			state_r.sda_oe_n <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata    = state_r.rdata;
	assign ee_cs        = state_r.cs;
	assign ee_sck       = state_r.sck;
	assign ee_sdo       = state_r.sdo;
	assign scl_out      = state_r.scl_out;
	assign scl_oe_n     = state_r.scl_oe_n;
	assign sda_out      = state_r.sda_out;
	assign sda_oe_n     = state_r.sda_oe_n;
	assign config_ready = state_r.ready;
	assign cfg_data     = state_r.cfg_data;
	assign cfg_valid    = state_r.cfg_valid;
endmodule

// ===== eeprom_ctl_sva.sv
// Port-level checks for the serial EEPROM command controller
`timescale 1ns/10ps
module eeprom_ctl_sva
	import eeprom_ctl_pkg::*;
	#(parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC) (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        i2c_mode,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        ee_cs,
	input wire logic        ee_sck,
	input wire logic        config_ready,
	input wire logic        cfg_valid
);
	// Longest chip select: a full read frame or the whole status wait
	localparam int unsigned CS_MAX = TIMEOUT_CYCLES + 4000;
	logic        rd_d_r;
	logic        idle_r;
	logic [31:0] cs_cnt_r;
	logic        go;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// Idle is known only from a read of busy with no command write since
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_d_r   <= 1'b0;
			idle_r   <= 1'b0;
			cs_cnt_r <= '0;
		end else begin
			rd_d_r   <= reg_rd && reg_addr == CMD_OFS;
			if (reg_wr && reg_addr == CMD_OFS)
				idle_r <= 1'b0;
			else if (rd_d_r)
				idle_r <= !reg_rdata[BUSY_BIT];
			cs_cnt_r <= ee_cs ? cs_cnt_r + 32'h1 : 32'h0;
		end
	end
	assign go = idle_r && reg_wr && reg_addr == CMD_OFS && reg_wdata[BUSY_BIT];

	////////////////////////////////////////////////////////////////////////
	property p_start;
		go && !i2c_mode |-> ##[1:60] ee_cs;
	endproperty
	a_start: assert property (p_start) else $error("command never framed");
	property p_reload;
		go && reg_wdata[30:28] == CMD_RELOAD |-> ##[1:4] !config_ready;
	endproperty
	a_reload: assert property (p_reload) else $error("ready kept");
	property p_hwcfg;
		reg_rd && reg_addr == HWCFG_OFS |=>
			reg_rdata == {31'h0, $past(config_ready)};
	endproperty
	a_hwcfg: assert property (p_hwcfg) else $error("bad hw config");
	property p_data;
		reg_rd && reg_addr == DATA_OFS |=> reg_rdata[31:8] == 24'h0;
	endproperty
	a_data: assert property (p_data) else $error("data upper bits");
	property p_resv;
		reg_rd && reg_addr == CMD_OFS |=> reg_rdata[27:19] == 9'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_excl;
		reg_rd && reg_addr == CMD_OFS |=>
			!(reg_rdata[OVF_BIT] && reg_rdata[LOADED_BIT]);
	endproperty
	a_excl: assert property (p_excl) else $error("overrun and loaded");
	property p_pulse;
		cfg_valid |=> !cfg_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("config pulse long");
	property p_bound;
		cs_cnt_r <= CS_MAX;
	endproperty
	a_bound: assert property (p_bound) else $error("no return to idle");
	property p_mode;
		i2c_mode |-> !ee_cs && !ee_sck;
	endproperty
	a_mode: assert property (p_mode) else $error("three-wire in i2c");

	c_frame: cover property (ee_cs ##1 !ee_cs);
	c_cfg: cover property (cfg_valid);
	c_reload: cover property (go ##1 !config_ready);
endmodule

bind eeprom_ctl eeprom_ctl_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) sva_i (
	.sys_clk, .srst, .i2c_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .ee_cs, .ee_sck, .config_ready, .cfg_valid
);

// ===== eeprom_chip_model.sv
// Behavioural three-wire serial EEPROM, 256 bytes
`timescale 1ns/10ps
module eeprom_chip_model (
	input  wire logic cs,
	input  wire logic sck,
	input  wire logic sdo,
	input  wire logic present,
	input  wire logic pull_high,
	input  wire logic slow,
	output logic      dout
);
	logic [7:0]  mem [256];
	logic [18:0] sr;
	logic [18:0] f;
	int          cnt;
	logic        wr_en;
	logic        prog;
	logic        poll;
	logic        rd;
	logic        rbit;
	logic [7:0]  ra;
	localparam logic [7:0] SIG = 8'ha5;

	initial begin
		foreach (mem[i])
			mem[i] = 8'hff;
		mem[0] = SIG;
		mem[1] = 8'h01;
		mem[2] = 8'h77;
		wr_en  = 1'b0;
		prog   = 1'b0;
		poll   = 1'b0;
		cnt    = 0;
	end

	always @(posedge cs) begin
		cnt = 0;
		rd  = 1'b0;
	end
	always @(posedge sck) if (cs && !poll) begin
		if (rd && cnt >= 11 && cnt <= 18)
			rbit = mem[ra][18 - cnt];
		sr  = {sr[17:0], sdo};
		cnt = cnt + 1;
		if (cnt == 11) begin
			rd = sr[9:8] == 2'b10;
			ra = sr[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Frame decode at chip select fall; program ops then show busy if write enabled
	always @(negedge cs) begin
		if (poll)
			poll = 1'b0;
		else if (cnt == 11 || cnt == 19) begin
			f = (cnt == 11) ? {sr[10:0], 8'h00} : sr;
			if (f[17:16] == 2'b00 && f[15:14] == 2'b11)
				wr_en = 1'b1;
			else if (f[17:16] == 2'b00 && f[15:14] == 2'b00)
				wr_en = 1'b0;
			else if (f[17:16] != 2'b10) begin
				poll = 1'b1;
				if (wr_en) begin
					if (f[17:16] == 2'b01)
						mem[f[15:8]] = f[7:0];
					else if (f[17:16] == 2'b11)
						mem[f[15:8]] = 8'hff;
					else
						foreach (mem[i])
							mem[i] = f[15:14] == 2'b01 ? f[7:0] : 8'hff;
					prog = 1'b1;
					prog <= #(slow ? 3000 : 1000) 1'b0;
				end
			end
		end
	end
	// Absent chip leaves the line at pull_high; a deselected chip drives low
	assign dout = !present ? pull_high : !cs ? 1'b0 : poll ? !prog :
		(rd && cnt >= 12) ? rbit : 1'b0;
endmodule

// ===== serial_eeprom_command_control_tb.sv
// Register-level testbench for the serial EEPROM command controller
`timescale 1ns/10ps
module serial_eeprom_command_control_tb;
	import eeprom_ctl_pkg::*;
	logic        sys_clk;
	logic        srst;
	logic        i2c_mode;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        ee_cs;
	logic        ee_sck;
	logic        ee_sdo;
	logic        serial_data_in_pin;
	logic        scl_in;
	logic        scl_out;
	logic        scl_oe_n;
	logic        sda_in;
	logic        sda_out;
	logic        sda_oe_n;
	logic        config_ready;
	logic [7:0]  cfg_data;
	logic        cfg_valid;
	logic        present;
	logic        pull_high;
	logic        slow;
	logic [31:0] d;
	logic [7:0]  cfg_q [$];
	int          failures;
	int          n_compared;

	// Both wires pulled up; no I2C device ever acknowledges
	assign scl_in = scl_oe_n;
	assign sda_in = sda_oe_n;

	eeprom_ctl #(.EE_LAST_ADDR(16'h0004), .TIMEOUT_CYCLES(200)) dut (
		.sys_clk, .srst, .i2c_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ee_cs, .ee_sck, .ee_sdo, .serial_data_in_pin, .scl_in,
		.scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .config_ready,
		.cfg_data, .cfg_valid
	);
	eeprom_chip_model ee (.cs(ee_cs), .sck(ee_sck), .sdo(ee_sdo),
		.present, .pull_high, .slow, .dout(serial_data_in_pin));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (cfg_valid === 1'b1)
		cfg_q.push_back(cfg_data);

	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task wait_idle;
		int i;
		for (i = 0; i < 15000; i++) begin
			rd(CMD_OFS, d);
			if (d[BUSY_BIT] === 1'b0)
				break;
		end
		if (i == 15000) begin
			failures++;
			$display("unexpected busy: expected 0 seen 1");
		end
	endtask
	task cmd(input logic [2:0] c, input logic [15:0] a);
		wr(CMD_OFS, {1'b1, c, 12'h000, a});
		wait_idle;
	endtask
	task flags(input string n, input logic [2:0] e);
		rd(CMD_OFS, d);
		chk(n, {29'h0, e}, {29'h0, d[18:16]});
	endtask
	task peek(input string n, input logic [15:0] a, input logic [7:0] e);
		cmd(CMD_READ, a);
		rd(DATA_OFS, d);
		chk(n, {24'h0, e}, d);
	endtask
	task wrap_up;
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#2800000;
		failures++;
		wrap_up;
	end
	initial begin
		{srst, i2c_mode, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		srst       = 1'b1;
		present    = 1'b1;
		pull_high  = 1'b0;
		slow       = 1'b0;
		failures   = 0;
		n_compared = 0;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CMD_OFS, d);
		chk("cmd_reset", 32'h8000_0000, d);
		wait_idle;
		flags("loaded", 3'b001);
		chk("cfg_count", 32'd1, cfg_q.size());
		chk("cfg_byte", 32'h77, {24'h0, cfg_q[0]});
		rd(HWCFG_OFS, d);
		chk("ready", 32'h1, d);
		rd(8'h0c, d);
		chk("unmapped", 32'h0, d);
		wr(CMD_OFS, 32'h0);
		flags("keep_w0", 3'b001);
		wr(CMD_OFS, 32'h0001_0000);
		flags("clear_w1", 3'b000);
		peek("read", 16'h0002, 8'h77);
		wr(DATA_OFS, 32'h3c);
		cmd(CMD_WRITE, 16'h0005);
		peek("locked", 16'h0005, 8'hff);
		cmd(CMD_EW_ON, 16'h0000);
		wr(DATA_OFS, 32'h3c);
		slow = 1'b1;
		wr(CMD_OFS, {1'b1, CMD_WRITE, 28'h0005});
		wr(DATA_OFS, 32'h00);
		wait_idle;
		slow = 1'b0;
		rd(DATA_OFS, d);
		chk("busy_data", 32'h3c, d);
		peek("written", 16'h0005, 8'h3c);
		cmd(CMD_EW_OFF, 16'h0000);
		wr(DATA_OFS, 32'h00);
		cmd(CMD_WRITE, 16'h0005);
		peek("disabled", 16'h0005, 8'h3c);
		cmd(CMD_EW_ON, 16'h0000);
		cmd(CMD_ERASE, 16'h0005);
		peek("erased", 16'h0005, 8'hff);
		wr(DATA_OFS, 32'ha5);
		cmd(CMD_WR_ALL, 16'h0000);
		peek("write_all_cmd", 16'h0003, 8'ha5);
		wr(CMD_OFS, {1'b1, CMD_RELOAD, 28'h0});
		repeat (2) @(posedge sys_clk);
		rd(HWCFG_OFS, d);
		chk("not_ready", 32'h0, d);
		wait_idle;
		flags("overrun", 3'b100);
		cmd(CMD_ER_ALL, 16'h0000);
		peek("erase_all_cmd", 16'h0003, 8'hff);
		cmd(CMD_RELOAD, 16'h0000);
		flags("bad_sig", 3'b000);
		present = 1'b0;
		cmd(CMD_WRITE, 16'h0005);
		flags("absent_wr", 3'b010);
		wr(CMD_OFS, 32'h0002_0000);
		peek("absent_rd", 16'h0005, 8'h00);
		flags("absent_rd", 3'b000);
		pull_high = 1'b1;
		cmd(CMD_ERASE, 16'h0005);
		flags("pulled_hi", 3'b000);
		present = 1'b1;
		@(posedge sys_clk) i2c_mode <= 1'b1;
		cmd(CMD_EW_ON, 16'h0000);
		flags("i2c_unsup", 3'b010);
		wr(CMD_OFS, 32'h0002_0000);
		cmd(CMD_READ, 16'h0000);
		flags("i2c_nack", 3'b010);
		wrap_up;
	end
endmodule
